// *** core/sfpes_pkg.sv ***
package sfpes_pkg;
	////////////////////////////////////////////////////////////////////////////
	// framing and geometry
	localparam logic [5:0]  OP_BITS     = 6'h08;
	localparam logic [5:0]  HDR_BITS    = 6'h20;
	localparam logic [11:0] PAGE_BYTES  = 12'h108;
	localparam logic [11:0] BLOCK_BYTES = 12'h840;
	localparam logic [8:0]  BUF_LAST    = 9'h107;
	localparam int          STAT_READY  = 7;
	localparam int          STAT_COMP   = 6;
	localparam int          PAGE_LSB    = 9;
	localparam int          BLOCK_LSB   = 12;
	////////////////////////////////////////////////////////////////////////////
	// opcodes
	localparam logic [7:0] OP_WR1   = 8'h84;
	localparam logic [7:0] OP_WR2   = 8'h87;
	localparam logic [7:0] OP_PGE1  = 8'h83;
	localparam logic [7:0] OP_PGE2  = 8'h86;
	localparam logic [7:0] OP_PG1   = 8'h88;
	localparam logic [7:0] OP_PG2   = 8'h89;
	localparam logic [7:0] OP_PERS  = 8'h81;
	localparam logic [7:0] OP_BERS  = 8'h50;
	localparam logic [7:0] OP_THR1  = 8'h82;
	localparam logic [7:0] OP_THR2  = 8'h85;
	localparam logic [7:0] OP_XFR1  = 8'h53;
	localparam logic [7:0] OP_XFR2  = 8'h55;
	localparam logic [7:0] OP_CMP1  = 8'h60;
	localparam logic [7:0] OP_CMP2  = 8'h61;
	localparam logic [7:0] OP_RWR1  = 8'h58;
	localparam logic [7:0] OP_RWR2  = 8'h59;
	localparam logic [7:0] OP_STAT  = 8'h57;
	localparam logic [7:0] OP_STATM = 8'hD7;
	////////////////////////////////////////////////////////////////////////////
	// timing
	localparam int          CLK_PERIOD_NS = 100;
	localparam int          SCK_PERIOD_NS = 800;
	localparam int          EP_US   = 20000;
	localparam int          P_US    = 14000;
	localparam int          PE_US   = 8000;
	localparam int          BE_US   = 12000;
	localparam int          XFR_US  = 300;
	localparam logic [31:0] EP_CYC  = 32'(EP_US * 1000 / CLK_PERIOD_NS);
	localparam logic [31:0] P_CYC   = 32'(P_US * 1000 / CLK_PERIOD_NS);
	localparam logic [31:0] PE_CYC  = 32'(PE_US * 1000 / CLK_PERIOD_NS);
	localparam logic [31:0] BE_CYC  = 32'(BE_US * 1000 / CLK_PERIOD_NS);
	localparam logic [31:0] XFR_CYC = 32'(XFR_US * 1000 / CLK_PERIOD_NS);
	localparam logic [7:0]  SCK_HALF_CYC = 8'(SCK_PERIOD_NS / (2 * CLK_PERIOD_NS));
	////////////////////////////////////////////////////////////////////////////
	// host registers
	localparam logic [7:0] REG_CTRL     = 8'h00;
	localparam logic [7:0] REG_STAT     = 8'h04;
	localparam int         CTRL_KEEP    = 8;
	localparam int         CTRL_RELEASE = 9;
	////////////////////////////////////////////////////////////////////////////
	// device state
	typedef enum logic [2:0] {
		SEQ_IDLE = 3'b001,
		SEQ_WALK = 3'b010,
		SEQ_WAIT = 3'b100
	} sfpes_seq_t;
	typedef enum logic [4:0] {
		ACT_ERASE   = 5'h01,
		ACT_PROG    = 5'h02,
		ACT_PROG_NE = 5'h04,
		ACT_LOAD    = 5'h08,
		ACT_CMP     = 5'h10
	} sfpes_act_t;
	typedef struct packed {
		logic [1:0]  sck_s;
		logic [1:0]  cs_s;
		logic [1:0]  si_s;
		logic        sck_q;
		logic        cs_q;
		logic [7:0]  cmd;
		logic [23:0] addr;
		logic [5:0]  nbits;
		logic [6:0]  dsh;
		logic [2:0]  dcnt;
		logic [8:0]  wptr;
		logic        rd_stat;
		logic        shown;
		logic [2:0]  sidx;
		logic        so;
		logic        so_oe_n;
		sfpes_seq_t  seq;
		sfpes_act_t  act;
		logic        bsel;
		logic [10:0] page;
		logic [11:0] widx;
		logic [11:0] wlen;
		logic [31:0] timer;
		logic        diff;
		logic        comp;
	} sfpes_dev_st_t;
	localparam sfpes_dev_st_t DEV_RST = '{sck_s: 2'h0, cs_s: 2'h3, si_s: 2'h0, sck_q: 1'b0,
		cs_q: 1'b1, cmd: 8'h00, addr: 24'h000000, nbits: 6'h00, dsh: 7'h00, dcnt: 3'h0,
		wptr: 9'h000, rd_stat: 1'b0, shown: 1'b0, sidx: 3'h7, so: 1'b0, so_oe_n: 1'b1,
		seq: SEQ_IDLE, act: ACT_ERASE, bsel: 1'b0, page: 11'h000, widx: 12'h000,
		wlen: 12'h000, timer: 32'h0, diff: 1'b0, comp: 1'b0};
	////////////////////////////////////////////////////////////////////////////
	// host state
	typedef enum logic [1:0] {
		HOST_IDLE  = 2'b01,
		HOST_SHIFT = 2'b10
	} sfpes_host_seq_t;
	typedef struct packed {
		sfpes_host_seq_t seq;
		logic [7:0]      half;
		logic [2:0]      bits;
		logic            sck;
		logic            cs_n;
		logic [7:0]      tx;
		logic [7:0]      rx;
		logic [7:0]      rx_byte;
		logic            keep;
		logic [1:0]      so_s;
		logic [31:0]     prdata;
	} sfpes_host_st_t;
	localparam sfpes_host_st_t HOST_RST = '{seq: HOST_IDLE, half: 8'h00, bits: 3'h0,
		sck: 1'b0, cs_n: 1'b1, tx: 8'h00, rx: 8'h00, rx_byte: 8'h00, keep: 1'b0,
		so_s: 2'h3, prdata: 32'h0};
endpackage

// *** core/sfpes_link_if.sv ***
interface sfpes_link_if;
	logic sck;
	logic cs_n;
	logic si;
	logic so;
	logic so_oe_n;
	logic so_wire;
	// released output reads as the pull-up level
	assign so_wire = so_oe_n ? 1'b1 : so;
	modport device (input sck, input cs_n, input si, output so, output so_oe_n);
	modport host (output sck, output cs_n, output si, input so_wire);
endinterface

// *** core/sfpes_device.sv ***
// Overview of operation
// - status bit 7 high when ready
// - halted clock keeps live ready bit on output
// - busy during transfer, compare, program, rewrite
// - status bit 6 holds last compare mismatch
// - status bits 5..2 fixed density code
// - buffer write 84/87, ignored bits, start address
// - buffer write stores bytes wrapping until select
// - program with erase 83/86 address layout
// - select rise erases then programs page
// - program without erase 88/89, program_time
// - host programs only erased pages
// - page erase 81, sets page to ones
// - block erase 50, eight pages to ones
// - block number from page address bits 10..3
// - program through buffer 82/85, data wraps
// - through buffer erases and programs page
// - page to buffer transfer 53/55 layout
// - transfer starts on select rise, pollable
// - host holds select low through command
// - everything shifted most significant bit first
// - sample on rising, change on falling
// - status opcode 57/D7 repeats eight bits
// - host starts no array operation while busy
module sfpes_device #(
	parameter logic [31:0] EP_CYC  = sfpes_pkg::EP_CYC,
	parameter logic [31:0] P_CYC   = sfpes_pkg::P_CYC,
	parameter logic [31:0] PE_CYC  = sfpes_pkg::PE_CYC,
	parameter logic [31:0] BE_CYC  = sfpes_pkg::BE_CYC,
	parameter logic [31:0] XFR_CYC = sfpes_pkg::XFR_CYC,
	parameter int          PAGES   = 2048,
	parameter logic [3:0]  DENSITY = 4'hA // arbitrary value
) (
	// clock and reset
	input  wire logic    pclk,
	input  wire logic    presetn,
	input  wire logic    ce,
	// flash link
	sfpes_link_if.device link,
	// user side
	output logic         busy
);
	////////////////////////////////////////////////////////////////////////////
	// storage: two page buffers and the array
	logic [7:0] bufm [2 * sfpes_pkg::PAGE_BYTES];
	logic [7:0] mem [PAGES * sfpes_pkg::PAGE_BYTES];

	sfpes_pkg::sfpes_dev_st_t r;
	sfpes_pkg::sfpes_dev_st_t next_r;
	logic                     bw_we;
	logic [9:0]               bw_a;
	logic [7:0]               bw_d;
	logic                     bl_we;
	logic [9:0]               bl_a;
	logic [7:0]               mw_d;
	logic                     mw_we;
	logic [19:0]              m_a;
	logic [7:0]               m_q;
	logic [7:0]               b_q;
	logic [7:0]               stat;
	logic                     rise;
	logic                     fall;
	logic                     cs_up;
	logic                     si;
	logic [7:0]               opc;

	////////////////////////////////////////////////////////////////////////////
	// helpers
	function automatic logic [9:0] buf_addr(input logic sel, input logic [8:0] off);
		buf_addr = sel ? 10'(off) + 10'(sfpes_pkg::PAGE_BYTES) : 10'(off);
	endfunction

	function automatic logic is_second(input logic [7:0] op);
		is_second = (op == sfpes_pkg::OP_WR2) || (op == sfpes_pkg::OP_PGE2) ||
			(op == sfpes_pkg::OP_PG2) || (op == sfpes_pkg::OP_THR2) ||
			(op == sfpes_pkg::OP_XFR2) || (op == sfpes_pkg::OP_CMP2) ||
			(op == sfpes_pkg::OP_RWR2);
	endfunction

	function automatic logic [8:0] next_ptr(input logic [8:0] p);
		next_ptr = (p >= sfpes_pkg::BUF_LAST) ? 9'h000 : p + 9'h001;
	endfunction

	////////////////////////////////////////////////////////////////////////////
	// status byte and edge strobes, all from second synchroniser stage
	assign stat = {~busy, r.comp, DENSITY, 2'b00};
	assign busy = (r.seq != sfpes_pkg::SEQ_IDLE);
	assign rise = r.sck_s[1] & ~r.sck_q & ~r.cs_s[1];
	assign fall = ~r.sck_s[1] & r.sck_q & ~r.cs_s[1];
	assign cs_up = r.cs_s[1] & ~r.cs_q;
	assign si = r.si_s[1];
	assign opc = {r.cmd[6:0], si};
	assign m_a = 20'(r.page) * 20'(sfpes_pkg::PAGE_BYTES) + 20'(r.widx);
	assign m_q = mem[m_a];
	assign b_q = bufm[buf_addr(r.bsel, r.widx[8:0])];
	assign link.so = r.so;
	assign link.so_oe_n = r.so_oe_n;

	////////////////////////////////////////////////////////////////////////////
	// next state
	always_comb begin
		next_r = r;
		bw_we = 1'b0;
		bw_a = buf_addr(is_second(r.cmd), r.wptr);
		bw_d = {r.dsh, si};
		bl_we = 1'b0;
		bl_a = buf_addr(r.bsel, r.widx[8:0]);
		mw_we = 1'b0;
		mw_d = 8'hFF;
		next_r.sck_s = {r.sck_s[0], link.sck};
		next_r.cs_s = {r.cs_s[0], link.cs_n};
		next_r.si_s = {r.si_s[0], link.si};
		next_r.sck_q = r.sck_s[1];
		next_r.cs_q = r.cs_s[1];
		// command and address, msb first on the rising edge
		if (rise) begin
			if (r.nbits < sfpes_pkg::OP_BITS) begin
				next_r.cmd = opc;
				if ((r.nbits == sfpes_pkg::OP_BITS - 6'h01) &&
					((opc == sfpes_pkg::OP_STAT) || (opc == sfpes_pkg::OP_STATM))) begin
					next_r.rd_stat = 1'b1;
					next_r.shown = 1'b0;
					next_r.sidx = 3'h7;
				end
			end else if (r.nbits < sfpes_pkg::HDR_BITS) begin
				next_r.addr = {r.addr[22:0], si};
				next_r.wptr = {r.addr[7:0], si};
			end
			if (r.nbits < sfpes_pkg::HDR_BITS) begin
				next_r.nbits = r.nbits + 6'h01;
			end else begin
				// data bytes land in the buffer, wrapping at its end
				next_r.dsh = {r.dsh[5:0], si};
				next_r.dcnt = r.dcnt + 3'h1;
				if ((r.dcnt == 3'h7) && ((r.cmd == sfpes_pkg::OP_WR1) ||
					(r.cmd == sfpes_pkg::OP_WR2) || (r.cmd == sfpes_pkg::OP_THR1) ||
					(r.cmd == sfpes_pkg::OP_THR2))) begin
					bw_we = 1'b1;
					next_r.wptr = next_ptr(r.wptr);
				end
			end
		end
		// status bits leave on the falling edge, looping 7..0
		if (fall && r.rd_stat) begin
			if (!r.shown) begin
				next_r.shown = 1'b1;
			end else begin
				next_r.sidx = r.sidx - 3'h1;
			end
		end
		// refreshed every cycle so a parked clock still shows live ready
		next_r.so = r.rd_stat && r.shown && stat[r.sidx];
		next_r.so_oe_n = r.cs_s[1];
		if (r.cs_s[1]) begin
			next_r.nbits = 6'h00;
			next_r.dcnt = 3'h0;
			next_r.rd_stat = 1'b0;
			next_r.shown = 1'b0;
		end
		if (r.timer != 32'h0) begin
			next_r.timer = r.timer - 32'h1;
		end
		// self-timed sequencer
		unique case (r.seq)
			sfpes_pkg::SEQ_IDLE: begin
				// a partial header or a busy array launches nothing
				if (cs_up && (r.nbits == sfpes_pkg::HDR_BITS)) begin
					next_r.seq = sfpes_pkg::SEQ_WALK;
					next_r.widx = 12'h000;
					next_r.wlen = sfpes_pkg::PAGE_BYTES;
					next_r.page = r.addr[sfpes_pkg::PAGE_LSB +: 11];
					next_r.bsel = is_second(r.cmd);
					next_r.diff = 1'b0;
					case (r.cmd)
						sfpes_pkg::OP_PGE1, sfpes_pkg::OP_PGE2,
						sfpes_pkg::OP_THR1, sfpes_pkg::OP_THR2: begin
							next_r.act = sfpes_pkg::ACT_PROG;
							next_r.timer = EP_CYC;
						end
						sfpes_pkg::OP_PG1, sfpes_pkg::OP_PG2: begin
							next_r.act = sfpes_pkg::ACT_PROG_NE;
							next_r.timer = P_CYC;
						end
						sfpes_pkg::OP_PERS: begin
							next_r.act = sfpes_pkg::ACT_ERASE;
							next_r.timer = PE_CYC;
						end
						sfpes_pkg::OP_BERS: begin
							next_r.act = sfpes_pkg::ACT_ERASE;
							next_r.timer = BE_CYC;
							next_r.wlen = sfpes_pkg::BLOCK_BYTES;
							next_r.page = {r.addr[sfpes_pkg::BLOCK_LSB +: 8], 3'h0};
						end
						sfpes_pkg::OP_XFR1, sfpes_pkg::OP_XFR2: begin
							next_r.act = sfpes_pkg::ACT_LOAD;
							next_r.timer = XFR_CYC;
						end
						sfpes_pkg::OP_CMP1, sfpes_pkg::OP_CMP2: begin
							next_r.act = sfpes_pkg::ACT_CMP;
							next_r.timer = XFR_CYC;
						end
						sfpes_pkg::OP_RWR1, sfpes_pkg::OP_RWR2: begin
							next_r.act = sfpes_pkg::ACT_LOAD;
							next_r.timer = EP_CYC;
						end
						default: next_r.seq = sfpes_pkg::SEQ_IDLE;
					endcase
				end
			end
			sfpes_pkg::SEQ_WALK: begin
				// one byte per cycle; erase then program equals plain copy
				unique case (r.act)
					sfpes_pkg::ACT_ERASE: mw_we = 1'b1;
					sfpes_pkg::ACT_PROG: begin
						mw_we = 1'b1;
						mw_d = b_q;
					end
					sfpes_pkg::ACT_PROG_NE: begin
						mw_we = 1'b1; // programming only clears bits
						mw_d = m_q & b_q;
					end
					sfpes_pkg::ACT_LOAD: bl_we = 1'b1;
					sfpes_pkg::ACT_CMP: next_r.diff = r.diff | (m_q != b_q);
				endcase
				next_r.widx = r.widx + 12'h001;
				if (r.widx == r.wlen - 12'h001) begin
					next_r.seq = sfpes_pkg::SEQ_WAIT;
					if (r.act == sfpes_pkg::ACT_CMP) begin
						next_r.comp = r.diff | (m_q != b_q);
					end
				end
			end
			sfpes_pkg::SEQ_WAIT: begin
				if (r.timer == 32'h0) begin
					next_r.seq = sfpes_pkg::SEQ_IDLE;
				end
			end
		endcase
	end

	////////////////////////////////////////////////////////////////////////////
	// state register
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			r <= sfpes_pkg::DEV_RST;
		end else if (ce) begin
			r <= next_r;
		end
	end

	// arrays carry no reset; contents are undefined until written
	always_ff @(posedge pclk) begin
		if (ce && bw_we) begin
			bufm[bw_a] <= bw_d;
		end
		if (ce && bl_we) begin
			bufm[bl_a] <= m_q;
		end
		if (ce && mw_we) begin
			mem[m_a] <= mw_d;
		end
	end
endmodule // sfpes_device

// *** core/sfpes_host.sv ***
module sfpes_host #(
	parameter logic [7:0] SCK_HALF = sfpes_pkg::SCK_HALF_CYC
) (
	// clock and reset
	input  wire logic         pclk,
	input  wire logic         presetn,
	input  wire logic         ce,
	// apb slave
	input  wire logic         psel,
	input  wire logic         penable,
	input  wire logic         pwrite,
	input  wire logic [7:0]   paddr,
	input  wire logic [31:0]  pwdata,
	output logic      [31:0]  prdata,
	output logic              pready,
	output logic              pslverr,
	// flash link
	sfpes_link_if.host        link
);
	sfpes_pkg::sfpes_host_st_t r;
	sfpes_pkg::sfpes_host_st_t next_r;
	logic                      mapped;
	logic                      wr;
	logic                      busy;

	////////////////////////////////////////////////////////////////////////////
	// apb: zero wait states, read data latched in the setup cycle
	assign mapped = (paddr == sfpes_pkg::REG_CTRL) || (paddr == sfpes_pkg::REG_STAT);
	assign pready = 1'b1;
	assign pslverr = psel & penable & ~mapped;
	assign wr = psel & penable & pwrite & (paddr == sfpes_pkg::REG_CTRL);
	assign busy = (r.seq != sfpes_pkg::HOST_IDLE);
	assign prdata = r.prdata;
	assign link.sck = r.sck;
	assign link.cs_n = r.cs_n;
	assign link.si = r.tx[7];

	////////////////////////////////////////////////////////////////////////////
	// next state
	always_comb begin
		next_r = r;
		next_r.so_s = {r.so_s[0], link.so_wire};
		if (psel && !penable) begin
			next_r.prdata = (paddr == sfpes_pkg::REG_STAT) ?
				{15'h0000, ~r.cs_n, r.rx_byte, 7'h00, busy} : 32'h0;
		end
		unique case (r.seq)
			sfpes_pkg::HOST_IDLE: begin
				// orders arriving mid-byte are dropped, so none here
				if (wr && pwdata[sfpes_pkg::CTRL_RELEASE]) begin
					next_r.cs_n = 1'b1;
				end else if (wr) begin
					next_r.seq = sfpes_pkg::HOST_SHIFT;
					next_r.tx = pwdata[7:0];
					next_r.keep = pwdata[sfpes_pkg::CTRL_KEEP];
					next_r.cs_n = 1'b0;
					next_r.half = 8'h00;
					next_r.bits = 3'h0;
				end
			end
			sfpes_pkg::HOST_SHIFT: begin
				// sck is a divided pclk, idle low between bytes
				next_r.half = r.half + 8'h01;
				if (r.half == SCK_HALF - 8'h01) begin
					next_r.half = 8'h00;
					next_r.sck = ~r.sck;
					if (r.sck) begin
						// take so just before the far end moves it again
						next_r.rx = {r.rx[6:0], r.so_s[1]};
						next_r.tx = {r.tx[6:0], 1'b0};
						next_r.bits = r.bits + 3'h1;
						if (r.bits == 3'h7) begin
							next_r.seq = sfpes_pkg::HOST_IDLE;
							next_r.rx_byte = {r.rx[6:0], r.so_s[1]};
							next_r.cs_n = ~r.keep;
						end
					end
				end
			end
		endcase
	end

	////////////////////////////////////////////////////////////////////////////
	// state register
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			r <= sfpes_pkg::HOST_RST;
		end else if (ce) begin
			r <= next_r;
		end
	end
endmodule // sfpes_host

// *** test/sfpes_props.sv ***
module sfpes_props #(
	parameter int MIN_T = 32'h1EA,
	parameter int MAX_T = 32'hBC2
) (
	// clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// link and device status
	input wire logic sck,
	input wire logic cs_n,
	input wire logic si,
	input wire logic so,
	input wire logic so_oe_n,
	input wire logic busy
);
	typedef struct packed {
		logic [15:0] len;
	} sfpes_props_st_t;
	sfpes_props_st_t st;
	sfpes_props_st_t next_st;
	// length of the current busy stretch
	always_comb begin
		next_st = st;
		next_st.len = busy ? st.len + 16'h1 : 16'h0;
	end
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			st <= '0;
		end else begin
			st <= next_st;
		end
	end
	////////////////////////////////////////////////////////////////////////////
	default clocking cb @(posedge pclk);
	endclocking
	default disable iff (!presetn);
	sequence s_sck_high;
		sck [*3];
	endsequence
	sequence s_deselected;
		cs_n [*4];
	endsequence
	// ready bit may follow busy live, so only judge while busy is quiet
	property p_so_hold;
		s_sck_high ##0 (!so_oe_n && $stable(busy) && $past(busy, 2) == busy) |-> $stable(so);
	endproperty
	property p_sck_idle;
		cs_n |-> !sck;
	endproperty
	property p_cs_rise;
		$rose(cs_n) |-> !sck && !$past(sck);
	endproperty
	property p_si_hold;
		sck && $past(sck) |-> $stable(si);
	endproperty
	property p_oe_release;
		s_deselected |-> so_oe_n;
	endproperty
	property p_launch;
		$rose(busy) |-> cs_n && $past(cs_n, 2);
	endproperty
	property p_busy_min;
		$fell(busy) |-> st.len >= MIN_T;
	endproperty
	property p_busy_max;
		busy |-> st.len <= MAX_T;
	endproperty
	a_so_hold: assert property (p_so_hold) else $error("so moved while sck high");
	a_sck_idle: assert property (p_sck_idle) else $error("sck high while deselected");
	a_cs_rise: assert property (p_cs_rise) else $error("select rose with sck high");
	a_si_hold: assert property (p_si_hold) else $error("si moved while sck high");
	a_oe_release: assert property (p_oe_release) else $error("so driven while deselected");
	a_launch: assert property (p_launch) else $error("busy without select rise");
	a_busy_min: assert property (p_busy_min) else $error("busy too short");
	a_busy_max: assert property (p_busy_max) else $error("busy too long");
endmodule // sfpes_props

// *** test/tb_serial_flash_program_erase_seq.sv ***
module tb_serial_flash_program_erase_seq;
	timeunit 1ns;
	timeprecision 1ns;
	// shortened array times in clock cycles
	localparam logic [31:0] EP  = 32'h0BB8;
	localparam logic [31:0] PG  = 32'h07D0;
	localparam logic [31:0] PE  = 32'h03E8;
	localparam logic [31:0] BE  = 32'h09C4;
	localparam logic [31:0] XF  = 32'h01F4;
	localparam logic [3:0]  DEN = 4'hA; // arbitrary value
	logic        pclk     = 1'b0;
	logic        presetn  = 1'b0;
	logic        ce       = 1'b1;
	logic        psel     = 1'b0;
	logic        penable  = 1'b0;
	logic        pwrite   = 1'b0;
	logic [7:0]  paddr    = 8'h00;
	logic [31:0] pwdata   = 32'h0;
	logic [31:0] prdata;
	logic        pready;
	logic        pslverr;
	logic        busy;
	logic [31:0] rs       = 32'h0000B170;
	logic [7:0]  m_buf[2][264];
	logic [7:0]  m_mem[int];
	logic        m_comp   = 1'b0;
	int          failures = 0;
	int          n_checks = 0;
	int          cyc      = 0;
	int          bcnt     = 0;
	int          blen     = 0;
	sfpes_link_if link ();
	sfpes_host u_sfpes_host (.pclk, .presetn, .ce(ce), .psel, .penable, .pwrite, .paddr,
		.pwdata, .prdata, .pready, .pslverr, .link(link));
	sfpes_device #(.EP_CYC(EP), .P_CYC(PG), .PE_CYC(PE), .BE_CYC(BE), .XFR_CYC(XF),
		.DENSITY(DEN)) u_sfpes_device (.pclk, .presetn, .ce(ce), .link(link), .busy);
	sfpes_props #(.MIN_T(32'h1EA), .MAX_T(32'hBC2)) u_sfpes_props (.pclk, .presetn,
		.sck(link.sck), .cs_n(link.cs_n), .si(link.si), .so(link.so),
		.so_oe_n(link.so_oe_n), .busy);
	always #50 pclk = ~pclk;
	////////////////////////////////////////////////////////////////////////////
	// busy stretch length and run ceiling
	always @(posedge pclk) begin
		cyc <= cyc + 1;
		bcnt <= (busy === 1'b1) ? bcnt + 1 : 0;
		if (busy === 1'b0 && bcnt > 0) begin
			blen <= bcnt;
		end
		if (cyc == 60000) begin
			failures++;
			give_verdict();
		end
	end
	task automatic give_verdict();
		$display("checks %0d failures %0d", n_checks, failures);
		if (failures == 0 && n_checks > 0) begin
			$display("[ PASS ]");
		end else begin
			$display("[ FAIL ]");
		end
		$finish;
	endtask
	function automatic logic [7:0] rnd();
		rs ^= rs << 13;
		rs ^= rs >> 17;
		rs ^= rs << 5;
		return rs[7:0];
	endfunction
	task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
		n_checks++;
		if (got !== exp) begin
			failures++;
			$display("unexpected at %0t: %s got %h want %h", $time, what, got, exp);
		end
	endtask
	////////////////////////////////////////////////////////////////////////////
	// apb master: setup, then access until pready
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
		output logic [31:0] r, output logic e);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		@(posedge pclk);
		while (pready !== 1'b1) @(posedge pclk);
		r = prdata;
		e = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge pclk);
	endtask
	// one byte on the link, then poll until the engine is done
	task automatic xb(input logic [7:0] b, input logic k, output logic [7:0] rx);
		logic [31:0] r;
		logic        e;
		apb(1'b1, 8'h00, {22'h0, 1'b0, k, b}, r, e);
		r = 32'h1;
		while (r[0] !== 1'b0) apb(1'b0, 8'h04, 32'h0, r, e);
		rx = r[15:8];
	endtask
	task automatic rel();
		logic [31:0] r;
		logic        e;
		apb(1'b1, 8'h00, 32'h200, r, e);
	endtask
	function automatic logic [31:0] dur(input logic [7:0] oc);
		case (oc)
			8'h83, 8'h86, 8'h82, 8'h85, 8'h58, 8'h59: return EP;
			8'h88, 8'h89: return PG;
			8'h81: return PE;
			8'h50: return BE;
			8'h53, 8'h55, 8'h60, 8'h61: return XF;
			default: return 32'h0;
		endcase
	endfunction
	////////////////////////////////////////////////////////////////////////////
	// one command: header, data, launch, status while busy, model update
	task automatic op(input logic [7:0] oc, input logic [10:0] pg, input logic [8:0] sa,
		input int nd);
		logic [7:0]  s;
		logic [7:0]  d;
		logic [23:0] a;
		logic [31:0] t;
		logic        b;
		logic        e;
		int          k;
		t = dur(oc);
		b = oc inside {8'h87, 8'h86, 8'h89, 8'h85, 8'h55, 8'h61, 8'h59};
		a = {4'h0, pg, sa};
		k = sa;
		e = 1'b0;
		xb(oc, 1'b1, s);
		for (int i = 2; i >= 0; i--) xb(a[i*8 +: 8], 1'b1, s);
		for (int i = 0; i < nd; i++) begin
			d = rnd();
			xb(d, 1'b1, s);
			m_buf[b][k] = d;
			k = (k >= 263) ? 0 : k + 1;
		end
		rel();
		repeat (8) @(posedge pclk);
		chk(busy, (t != 0), "busy after launch");
		if (t == 0) return;
		xb(8'h57, 1'b1, s);
		xb(8'h00, 1'b1, s);
		chk(s, {1'b0, m_comp, DEN, 2'b00}, "status while busy");
		repeat (6) @(posedge pclk);
		chk(link.so_wire, 1'b0, "held ready bit busy");
		while (busy === 1'b1) @(posedge pclk);
		repeat (6) @(posedge pclk);
		chk(link.so_wire, 1'b1, "held ready bit ready");
		rel();
		chk(blen + 2 >= t && blen <= t + 6, 1'b1, "busy length");
		// behavioural view of the array and buffers
		for (int i = 0; i < 264; i++) begin
			k = int'(pg) * 264 + i;
			case (oc)
				8'h83, 8'h86, 8'h82, 8'h85: m_mem[k] = m_buf[b][i];
				8'h88, 8'h89: m_mem[k] = m_mem[k] & m_buf[b][i];
				8'h81: m_mem[k] = 8'hFF;
				8'h50: for (int j = 0; j < 8; j++) m_mem[int'({pg[10:3], 3'(j)}) * 264 + i] = 8'hFF;
				8'h53, 8'h55, 8'h58, 8'h59: m_buf[b][i] = m_mem[k];
				default: e = e | (m_mem[k] !== m_buf[b][i]);
			endcase
		end
		if (oc[7:1] == 7'h30) m_comp = e;
		xb(8'hD7, 1'b1, s);
		xb(8'h00, 1'b1, s);
		rel();
		chk(s, {1'b1, m_comp, DEN, 2'b00}, "status when ready");
	endtask
	////////////////////////////////////////////////////////////////////////////
	// main sequence; table entries are opcode, data count, other page, start
	initial begin
		logic [31:0] r;
		logic        e;
		logic [7:0]  s;
		logic [10:0] p;
		logic [10:0] q;
		logic [31:0] tab[$];
		tab = {32'h81000000, 32'h53000000, 32'h60000000, 32'h84300107, 32'h60000000,
			32'h83000000, 32'h60000000, 32'h50000000, 32'h60000000, 32'h55000000,
			32'h87400005, 32'h89000000, 32'h61000000, 32'h88010000, 32'h60010000,
			32'h86000000, 32'h85200000, 32'h61000000, 32'h82100100, 32'h60000000,
			32'h59000000, 32'h61000000};
		repeat (10) @(posedge pclk);
		presetn <= 1'b1;
		@(posedge pclk);
		apb(1'b0, 8'h08, 32'h0, r, e);
		chk(e, 1'b1, "unmapped error");
		apb(1'b0, 8'h00, 32'h0, r, e);
		chk(r, 32'h0, "control reads zero");
		apb(1'b0, 8'h04, 32'h0, r, e);
		chk(r, 32'h0, "host status at reset");
		xb(8'h57, 1'b1, s);
		xb(8'h00, 1'b1, s);
		chk(s, {2'b10, DEN, 2'b00}, "idle status");
		// freeze both ends mid-byte: a low enable must stall the shift engine
		apb(1'b1, 8'h00, 32'h100, r, e);
		ce <= 1'b0;
		repeat (100) @(posedge pclk);
		ce <= 1'b1;
		apb(1'b0, 8'h04, 32'h0, r, e);
		chk(r[0], 1'b1, "enable low froze engine");
		while (r[0] !== 1'b0) apb(1'b0, 8'h04, 32'h0, r, e);
		chk(r[15:8], {2'b10, DEN, 2'b00}, "status repeats");
		rel();
		p = 11'({rnd(), rnd()});
		q = {p[10:3], ~p[2:0]};
		foreach (tab[i]) op(tab[i][31:24], tab[i][16] ? q : p, tab[i][8:0], int'(tab[i][23:20]));
		// header cut short: no array operation may start
		xb(8'h81, 1'b1, s);
		xb(8'h00, 1'b1, s);
		rel();
		repeat (8) @(posedge pclk);
		chk(busy, 1'b0, "short header refused");
		give_verdict();
	end
endmodule // tb_serial_flash_program_erase_seq
